// *** serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side serial peer
// ----------------------------------------
module serial_peer (
    // Clock
    input wire logic aclk,
    // Pin from the block
    input wire logic tx_out,
    input wire logic tx_oe,
    // Pin to the block
    output logic rx_line
);
    logic drive_en = 1'b0; // Own frame in progress
    logic drive_val = 1'b1; // Level of own frame
    logic last_tx = 1'b1; // Last driven level
    // Released pin has no pull: show the inverse so stale data never passes
    always @(posedge aclk) begin
        if (tx_oe) begin
            last_tx <= tx_out;
        end
    end
    // Loops the driven pin back unless sending its own frame
    assign rx_line = drive_en ? drive_val : (tx_oe ? tx_out : ~last_tx);
    // Sends n bits from bit 0 upward, bpc clocks each
    task automatic send(input logic [15:0] bits, input int n, input int bpc);
        int i;
        drive_en <= 1'b1;
        for (i = 0; i < n; i++) begin
            drive_val <= bits[i];
            repeat (bpc) @(posedge aclk);
        end
        drive_en <= 1'b0;
    endtask : send
endmodule : serial_peer
`default_nettype wire

// *** spi_attached_uart_module.sv ***
// Contract
// [R01] Transmit pin driven only when both enabled
// [R02] Receive input used only when both enabled
// [R03] Interrupt events give low pulse to host
// [R04] Eight or nine data bits selectable
// [R05] Even, odd or no parity
// [R06] One or two stop bits
// [R07] Baud rate from 8-bit prescaler
// [R08] Flag parity, framing, noise, overrun errors
// [R09] Address detect interrupt on last bit one
// [R10] Transmitter and receiver enabled independently, full duplex
// [R11] Four-entry receive FIFO
// [R12] Separate transmit, receive, overrun, address interrupt sources
// [R13] Host link select held high when undriven; select_pullup stays low while aresetn is low
// [R14] Host supplies clock up to 20 MHz
// [R15] Start bit low, LSB first, idle high
// [R16] Overrun when FIFO full; no overwrite
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uart_spi_map.svh"
module spi_attached_uart_module import uart_spi_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Serial line
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe,
    // Host link
    input wire logic spi_select_in,
    output logic select_pullup,
    output logic irq,
    output logic host_irq_n
);
    // ----------------------------------------
    // Shared decode
    // ----------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        return a == `OFS_CTRL || a == `OFS_BAUD || a == `OFS_TXD || a == `OFS_RXD
            || a == `OFS_STAT || a == `OFS_MASK || a == `OFS_INFO;
    endfunction : is_mapped
    // Parity bit over the active data width; odd flips it
    function automatic logic par_of(input logic [8:0] d, input logic n9, input logic odd);
        return (^(n9 ? d : {1'b0, d[7:0]})) ^ odd;
    endfunction : par_of

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    ctrl_t ctrl, next_ctrl; // Mode and enables
    logic [7:0] baud, next_baud; // Prescaler reload
    logic [7:0] mask, next_mask; // Interrupt mask
    logic [7:0] status; // Sticky events
    logic [7:0] waddr, next_waddr; // Held write address
    logic [31:0] wd, next_wd; // Held write data
    logic [3:0] wst, next_wst; // Held byte strobes
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, lm, mv;
    logic [7:0] w1c; // Status bits to clear
    logic wr_txd, pop;
    logic [2:0] count; // FIFO fill level
    rx_word_t head; // Oldest FIFO entry
    logic sel_meta, sel_s, tx_full;
    line_state_t tx_st, rx_st;

    // Byte-lane mask from the held strobes
    assign lm = {{8{wst[3]}}, {8{wst[2]}}, {8{wst[1]}}, {8{wst[0]}}};

    // Address and data are taken in either order; the write lands once both are held
    always_comb begin
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_waddr = waddr;
        next_wd = wd;
        next_wst = wst;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_ctrl = ctrl;
        next_baud = baud;
        next_mask = mask;
        mv = 32'h0;
        wr_txd = 1'b0;
        w1c = 8'h00;
        pop = 1'b0;
        if (awvalid && awready) begin
            next_waddr = awaddr;
            next_awready = 1'b0;
        end
        if (wvalid && wready) begin
            next_wd = wdata;
            next_wst = wstrb;
            next_wready = 1'b0;
        end
        if (!awready && !wready && !bvalid) begin
            next_bvalid = 1'b1;
            next_bresp = is_mapped(waddr) ? `RESP_OK : `RESP_ERR;
            case (waddr)
                `OFS_CTRL: begin
                    mv = ({24'h0, ctrl} & ~lm) | (wd & lm);
                    next_ctrl = ctrl_t'(mv[7:0]); // R04 R05 R06 R10
                end
                `OFS_BAUD: begin
                    mv = ({24'h0, baud} & ~lm) | (wd & lm);
                    next_baud = mv[7:0]; // R07
                end
                `OFS_MASK: begin
                    mv = ({24'h0, mask} & ~lm) | (wd & lm);
                    next_mask = mv[7:0];
                end
                `OFS_TXD: wr_txd = wst[0] && wst[1];
                `OFS_STAT: w1c = wd[7:0] & lm[7:0];
                default: ;
            endcase
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = is_mapped(araddr) ? `RESP_OK : `RESP_ERR;
            case (araddr)
                `OFS_CTRL: next_rdata = {24'h0, ctrl};
                `OFS_BAUD: next_rdata = {24'h0, baud};
                `OFS_RXD: begin
                    // Reading the data word removes it from the FIFO
                    next_rdata = {19'h0, count != 3'h0, head};
                    pop = count != 3'h0; // R11
                end
                `OFS_STAT: next_rdata = {24'h0, status};
                `OFS_MASK: next_rdata = {24'h0, mask};
                `OFS_INFO: next_rdata = {26'h0, sel_s, tx_full, tx_st != LN_IDLE, count};
                default: next_rdata = 32'h0;
            endcase
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OK;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OK;
            waddr <= 8'h00;
            wd <= 32'h0;
            wst <= 4'h0;
            ctrl <= ctrl_t'(`CTRL_RST);
            baud <= `BAUD_RST;
            mask <= `MASK_RST;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            waddr <= next_waddr;
            wd <= next_wd;
            wst <= next_wst;
            ctrl <= next_ctrl;
            baud <= next_baud;
            mask <= next_mask;
        end
    end

    // ----------------------------------------
    // Synchronisers and baud prescaler
    // ----------------------------------------
    logic rx_meta, rx_s; // Receive pin, two stages
    logic [7:0] pcnt, next_pcnt;
    logic tick; // One pulse per sixteenth of a bit
    assign tick = pcnt == 8'h00;
    // Divide by baud + 1; a bit lasts sixteen ticks
    assign next_pcnt = tick ? baud : pcnt - 8'h01; // R07

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
            sel_meta <= 1'b1;
            sel_s <= 1'b1;
            select_pullup <= 1'b0;
            pcnt <= 8'h00;
        end else begin
            rx_meta <= rx_in;
            rx_s <= rx_meta;
            sel_meta <= spi_select_in;
            sel_s <= sel_meta;
            select_pullup <= 1'b1; // R13
            pcnt <= next_pcnt;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    logic ten; // Transmit side enabled
    line_state_t next_tx_st;
    logic [3:0] tcnt, next_tcnt, tbit, next_tbit;
    logic [8:0] tsh, next_tsh, tx_buf, next_tx_buf;
    logic next_tx_full, next_tx_out, tbend, ev_txe, ev_txi;
    assign ten = ctrl.uen && ctrl.txe; // R10
    assign tbend = tick && tcnt == `TICK_LAST;

    // One holding register feeds the shifter, so software can queue a character
    always_comb begin
        next_tx_st = tx_st;
        next_tcnt = (tick && tx_st != LN_IDLE) ? tcnt + 4'h1 : tcnt;
        next_tbit = tbit;
        next_tsh = tsh;
        next_tx_buf = tx_buf;
        next_tx_full = tx_full;
        ev_txe = 1'b0;
        ev_txi = 1'b0;
        // A write while the buffer is full is dropped
        if (wr_txd && ten && !tx_full) begin
            next_tx_full = 1'b1;
            next_tx_buf = wd[8:0];
        end
        unique case (tx_st)
            LN_IDLE: if (tx_full && tick) begin
                next_tx_st = LN_START;
                next_tsh = tx_buf;
                next_tx_full = 1'b0;
                next_tcnt = 4'h0;
                ev_txe = 1'b1; // R12
            end
            LN_START: if (tbend) begin
                next_tx_st = LN_DATA;
                next_tbit = 4'h0;
            end
            LN_DATA: if (tbend) begin
                next_tbit = tbit + 4'h1;
                if (tbit == (ctrl.nine ? 4'h8 : 4'h7)) begin // R04
                    next_tx_st = ctrl.par_en ? LN_PAR : LN_STOP; // R05
                    next_tbit = 4'h0;
                end
            end
            LN_PAR: if (tbend) begin
                next_tx_st = LN_STOP;
            end
            LN_STOP: if (tbend) begin
                if (ctrl.two_stop && tbit == 4'h0) begin
                    next_tbit = 4'h1; // R06
                end else begin
                    next_tx_st = LN_IDLE;
                    ev_txi = !next_tx_full; // R12
                end
            end
            default: next_tx_st = LN_IDLE;
        endcase
        if (!ten) begin
            next_tx_st = LN_IDLE;
            next_tx_full = 1'b0;
        end
        // Line level for the coming state, so the pin is registered
        unique case (next_tx_st)
            LN_START: next_tx_out = 1'b0; // R15
            LN_DATA: next_tx_out = next_tsh[next_tbit]; // R15
            LN_PAR: next_tx_out = par_of(next_tsh, ctrl.nine, ctrl.par_odd);
            default: next_tx_out = 1'b1;
        endcase
    end

    // Transmitter registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st <= LN_IDLE;
            tcnt <= 4'h0;
            tbit <= 4'h0;
            tsh <= 9'h000;
            tx_buf <= 9'h000;
            tx_full <= 1'b0;
            tx_out <= 1'b1;
            tx_oe <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tcnt <= next_tcnt;
            tbit <= next_tbit;
            tsh <= next_tsh;
            tx_buf <= next_tx_buf;
            tx_full <= next_tx_full;
            tx_out <= next_tx_out;
            tx_oe <= ten; // R01
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    logic ren, maj, noisy, rbend, rx_push;
    line_state_t next_rx_st;
    logic [3:0] rcnt, next_rcnt, rbit, next_rbit;
    logic [8:0] rsh, next_rsh;
    logic [2:0] samp, next_samp; // Three mid-bit samples
    logic rnoise, next_rnoise, rperr, next_rperr;
    rx_word_t rx_word;
    assign ren = ctrl.uen && ctrl.rxe; // R10
    // Majority vote; any disagreement marks noise
    assign maj = (samp[0] & samp[1]) | (samp[0] & samp[2]) | (samp[1] & samp[2]);
    assign noisy = (|samp) && !(&samp); // R08
    assign rbend = tick && rcnt == `TICK_LAST;

    always_comb begin
        next_rx_st = rx_st;
        next_rcnt = (tick && rx_st != LN_IDLE) ? rcnt + 4'h1 : rcnt;
        next_rbit = rbit;
        next_rsh = rsh;
        next_rnoise = rnoise;
        next_rperr = rperr;
        next_samp = samp;
        rx_push = 1'b0;
        rx_word = {rnoise | noisy, !maj, rperr, rsh}; // R08
        if (tick && rcnt >= `SAMP_A && rcnt <= `SAMP_C) begin
            next_samp = {samp[1:0], rx_s};
        end
        unique case (rx_st)
            LN_IDLE: if (tick && !rx_s) begin // R15
                next_rx_st = LN_START;
                next_rcnt = 4'h0;
            end
            // A start bit that votes high was a glitch; go back to idle
            LN_START: if (rbend) begin
                next_rx_st = maj ? LN_IDLE : LN_DATA;
                next_rbit = 4'h0;
                next_rsh = 9'h000;
                next_rnoise = noisy;
                next_rperr = 1'b0;
            end
            LN_DATA: if (rbend) begin
                next_rsh[rbit] = maj; // R15
                next_rnoise = rnoise | noisy;
                next_rbit = rbit + 4'h1;
                if (rbit == (ctrl.nine ? 4'h8 : 4'h7)) begin // R04
                    next_rx_st = ctrl.par_en ? LN_PAR : LN_STOP; // R05
                end
            end
            LN_PAR: if (rbend) begin
                next_rperr = maj != par_of(rsh, ctrl.nine, ctrl.par_odd); // R08
                next_rnoise = rnoise | noisy;
                next_rx_st = LN_STOP;
            end
            // Only the first stop bit is checked, so two-stop senders are also accepted
            LN_STOP: if (rbend) begin
                rx_push = 1'b1;
                next_rx_st = LN_IDLE;
            end
            default: next_rx_st = LN_IDLE;
        endcase
        if (!ren) begin
            next_rx_st = LN_IDLE; // R02
        end
    end

    // Receiver registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st <= LN_IDLE;
            rcnt <= 4'h0;
            rbit <= 4'h0;
            rsh <= 9'h000;
            samp <= 3'h7;
            rnoise <= 1'b0;
            rperr <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rcnt <= next_rcnt;
            rbit <= next_rbit;
            rsh <= next_rsh;
            samp <= next_samp;
            rnoise <= next_rnoise;
            rperr <= next_rperr;
        end
    end

    // ----------------------------------------
    // Receive FIFO and interrupts
    // ----------------------------------------
    rx_word_t mem [4], next_mem [4];
    logic [1:0] wp, next_wp, rp, next_rp;
    logic [2:0] next_count;
    logic [7:0] ev, next_status;
    logic fifo_wr;
    assign head = mem[rp];

    always_comb begin
        next_mem = mem;
        // A full FIFO refuses the character, even if a read pops this cycle
        fifo_wr = rx_push && count != `RX_DEPTH; // R16
        next_wp = fifo_wr ? wp + 2'h1 : wp;
        next_rp = pop ? rp + 2'h1 : rp;
        next_count = count + {2'h0, fifo_wr} - {2'h0, pop}; // R11
        if (fifo_wr) begin
            next_mem[wp] = rx_word;
        end
        ev = 8'h00;
        ev[`ST_TXE] = ev_txe;
        ev[`ST_TXI] = ev_txi;
        ev[`ST_RXF] = fifo_wr; // R12
        ev[`ST_OVR] = rx_push && !fifo_wr; // R16
        ev[`ST_ADR] = rx_push && ctrl.addr_en && (ctrl.nine ? rsh[8] : rsh[7]); // R09
        ev[`ST_PAR] = rx_push && rx_word.parity;
        ev[`ST_FRM] = rx_push && rx_word.frame;
        ev[`ST_NOI] = rx_push && rx_word.noise;
        // A new event wins over a clear in the same cycle
        next_status = (status & ~w1c) | ev;
    end

    // FIFO and interrupt registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem <= '{default: '0};
            wp <= 2'h0;
            rp <= 2'h0;
            count <= 3'h0;
            status <= 8'h00;
            irq <= 1'b0;
            host_irq_n <= 1'b1;
        end else begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            count <= next_count;
            status <= next_status;
            irq <= |(next_status & next_mask);
            // Same mask as the level output, so a pulse never lacks a set irq
            host_irq_n <= !(|(ev & next_mask)); // R03
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_full_push;
        rx_push && count == `RX_DEPTH && !pop;
    endsequence
    a_tx_hiz_off: assert property (tx_oe |-> $past(ctrl.uen) && $past(ctrl.txe)) // R01
        else $error("tx driven while disabled");
    a_rx_held_idle: assert property (!ren |=> rx_st == LN_IDLE) // R02
        else $error("receiver ran while disabled");
    a_irq_low_pulse: assert property (!host_irq_n |-> irq) // R03
        else $error("host pulse without unmasked status");
    a_parity_slot: assert property (tx_st == LN_PAR |-> ctrl.par_en) // R05
        else $error("parity sent while disabled");
    a_start_low: assert property (tx_st == LN_START |-> !tx_out) // R15
        else $error("start bit not low");
    a_idle_high: assert property (tx_st == LN_IDLE |-> tx_out) // R15
        else $error("idle line not high");
    a_tick_gap: assert property (tick && baud != 8'h00 |=> !tick) // R07
        else $error("prescaler ticked twice");
    a_fifo_bound: assert property (count <= `RX_DEPTH) // R11
        else $error("fifo over four entries");
    a_overrun_keep: assert property (s_full_push |=> status[`ST_OVR] && count == `RX_DEPTH // R16
        && $stable(wp))
        else $error("overrun lost or overwrote");
    a_addr_event: assert property (rx_push && ctrl.addr_en // R09
        && (ctrl.nine ? rsh[8] : rsh[7]) |=> status[`ST_ADR])
        else $error("address detect missed");
endmodule : spi_attached_uart_module
`default_nettype wire

// *** test_spi_attached_uart_module.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_spi_map.svh"
module test_spi_attached_uart_module;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, spi_select_in = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, rx_in, tx_out, tx_oe, select_pullup;
    logic irq, host_irq_n;
    int miscompares = 0, n_compared = 0, cyc = 0, pulses = 0, p;
    spi_attached_uart_module u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .rx_in, .tx_out, .tx_oe, .spi_select_in,
        .select_pullup, .irq, .host_irq_n);
    serial_peer u_peer (.aclk, .tx_out, .tx_oe, .rx_line(rx_in));
    // Clock and cycle ceiling; counts interrupt pulses to the host
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (host_irq_n === 1'b0) pulses++;
        if (cyc == 30000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Sends one character and checks every bit on the pin at mid-bit
    task automatic tx_frame(input logic [7:0] c, input logic [8:0] v);
        logic [12:0] f;
        int n, i;
        f = 13'h1fff;
        n = c[3] ? 9 : 8;
        f[0] = 1'b0;
        for (i = 0; i < n; i++) f[i + 1] = v[i];
        if (c[4]) f[n + 1] = (c[3] ? ^v : ^v[7:0]) ^ c[5];
        n = n + 2 + c[4] + c[6];
        wr(`OFS_CTRL, {24'h0, c});
        wr(`OFS_TXD, {23'h0, v});
        chk(tx_oe, 1, "tx enable");
        i = 0;
        while (tx_out !== 1'b0 && i < 500) begin
            @(posedge aclk);
            i++;
        end
        repeat (8) @(posedge aclk);
        for (i = 0; i < n; i++) begin
            chk(tx_out, f[i], "tx bit");
            repeat (16) @(posedge aclk);
        end
    endtask : tx_frame
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(`OFS_CTRL);
        chk(d, 0, "ctrl reset");
        rd(`OFS_BAUD);
        chk(d, 32'h0f, "baud reset");
        rd(8'h1c);
        chk(d, 0, "unmapped data");
        chk(r, 2, "unmapped read");
        wr(8'h1c, 32'h1);
        chk(r, 2, "unmapped write");
        chk(tx_oe, 0, "tx off");
        chk(select_pullup, 1, "pullup");
        spi_select_in <= 1'b0;
        rd(`OFS_INFO);
        rd(`OFS_INFO);
        chk(d[5], 0, "select sync");
        spi_select_in <= 1'b1;
    endtask : t_reset
    // Receive disabled, then three formats looped back in full duplex
    task automatic t_formats();
        logic [7:0] cf [3];
        logic [8:0] dv [3];
        cf = '{8'h07, 8'h17, 8'h7f};
        dv = '{9'h05a, 9'h0c3, 9'h1a5};
        wr(`OFS_BAUD, 32'h0);
        tx_frame(8'h03, 9'h033);
        rd(`OFS_INFO);
        chk(d[2:0], 0, "rx off");
        for (int k = 0; k < 3; k++) tx_frame(cf[k], dv[k]);
        repeat (32) @(posedge aclk);
        for (int k = 0; k < 3; k++) begin
            rd(`OFS_RXD);
            chk(d[12:0], {4'h8, dv[k]}, "rx char");
        end
    endtask : t_formats
    task automatic t_overrun();
        for (int k = 1; k < 6; k++) tx_frame(8'h07, k[8:0]);
        repeat (32) @(posedge aclk);
        rd(`OFS_INFO);
        chk(d[2:0], 4, "fifo count");
        rd(`OFS_STAT);
        chk(d[3], 1, "overrun");
        rd(`OFS_RXD);
        chk(d[12:0], 13'h1001, "oldest kept");
    endtask : t_overrun
    task automatic t_addr();
        wr(`OFS_STAT, 32'hff);
        wr(`OFS_MASK, 32'h10);
        p = pulses;
        tx_frame(8'h87, 9'h080);
        repeat (32) @(posedge aclk);
        rd(`OFS_STAT);
        chk(d[4], 1, "addr flag");
        chk(irq, 1, "irq up");
        chk(pulses - p, 1, "one pulse");
        wr(`OFS_STAT, 32'h10);
        repeat (2) @(posedge aclk);
        chk(irq, 0, "irq cleared");
    endtask : t_addr
    // Peer sends a low stop bit
    task automatic t_frame_err();
        repeat (4) rd(`OFS_RXD);
        u_peer.send(16'h0066, 10, 16);
        repeat (48) @(posedge aclk);
        rd(`OFS_RXD);
        chk(d[12:0], 13'h1433, "framing");
    endtask : t_frame_err
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_formats();
        t_overrun();
        t_addr();
        t_frame_err();
        give_verdict();
    end
endmodule : test_spi_attached_uart_module
`default_nettype wire

// *** uart_spi_map.svh ***
`ifndef UART_SPI_MAP_SVH
`define UART_SPI_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_BAUD 8'h04
`define OFS_TXD 8'h08
`define OFS_RXD 8'h0c
`define OFS_STAT 8'h10
`define OFS_MASK 8'h14
`define OFS_INFO 8'h18
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST 8'h00
`define BAUD_RST 8'h0f
`define MASK_RST 8'h00
// ----------------------------------------
// Status and mask bit positions
// ----------------------------------------
`define ST_TXE 0
`define ST_TXI 1
`define ST_RXF 2
`define ST_OVR 3
`define ST_ADR 4
`define ST_PAR 5
`define ST_FRM 6
`define ST_NOI 7
// ----------------------------------------
// Timing: sixteen baud ticks per bit; receive FIFO depth
// ----------------------------------------
`define TICK_LAST 4'hf
`define SAMP_A 4'h7
`define SAMP_C 4'h9
`define RX_DEPTH 3'h4
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// *** uart_spi_pkg.sv ***
package uart_spi_pkg;
    // Serial line sequencer states, shared by both directions
    typedef enum logic [2:0] {
        LN_IDLE = 3'h0,
        LN_START = 3'h1,
        LN_DATA = 3'h2,
        LN_PAR = 3'h3,
        LN_STOP = 3'h4
    } line_state_t;
    // Control register fields, bit 0 first from the right
    typedef struct packed {
        logic addr_en;
        logic two_stop;
        logic par_odd;
        logic par_en;
        logic nine;
        logic rxe;
        logic txe;
        logic uen;
    } ctrl_t;
    // One received character with its error flags
    typedef struct packed {
        logic noise;
        logic frame;
        logic parity;
        logic [8:0] data;
    } rx_word_t;
endpackage : uart_spi_pkg
